//--- rtl/pcbu_regs.svh
// Constants for the program counter branch unit
`ifndef PCBU_REGS_SVH
`define PCBU_REGS_SVH
`define PCBU_PC_W 16
`define PCBU_DISP_W 8
`define PCBU_DISP_SIGN 7
`define PCBU_LEN_W 3
`define PCBU_PC_RESET 16'h0000
`define PCBU_LEN_ZERO 3'h0
`endif

//--- rtl/pcbu_pkg.sv
// Types shared by the program counter branch unit
package pcbu_pkg;
    typedef enum logic [1:0] {
        PCBU_OP_SEQ = 2'b00,
        PCBU_OP_REL = 2'b01,
        PCBU_OP_ABS_JMP = 2'b11,
        PCBU_OP_ABS_CALL = 2'b10
    } pcbu_op_t;

    typedef struct packed {
        pcbu_op_t op;
        logic cond_branch;
        logic cond_met;
        logic [2:0] length;
        logic [7:0] displacement;
        logic [15:0] target;
    } pcbu_instr_t;

    typedef enum logic [1:0] {
        PCBU_ST_RUN = 2'b00,
        PCBU_ST_REDIRECT = 2'b01
    } pcbu_state_t;
endpackage : pcbu_pkg

//--- rtl/pcbu_target.sv
// Relative target adder with sign extension
`timescale 1ns/1ps
`default_nettype none
`include "pcbu_regs.svh"
module pcbu_target #(
    parameter int PC_W = `PCBU_PC_W,
    parameter int DISP_W = `PCBU_DISP_W
) (
    // Operands
    input wire logic [PC_W-1:0] i_next_pc,
    input wire logic [DISP_W-1:0] i_disp,
    // Result
    output logic [PC_W-1:0] o_target
);
    logic [PC_W-1:0] disp_ext;
    assign disp_ext = {{(PC_W-DISP_W){i_disp[`PCBU_DISP_SIGN]}}, i_disp};
    assign o_target = i_next_pc + disp_ext;
endmodule : pcbu_target
`default_nettype wire

//--- rtl/pcbu_core.sv
// Program counter next-address and branch logic
//
// Notes on behaviour
// - Without a branch the counter advances by the instruction's byte count.
// - A taken branch loads the computed destination instead of the sequential value.
// - A relative target is the displacement added to the next instruction's address.
// - The displacement is signed with bit 7 as sign, reaching -128 to +127.
// - The displacement is sign-extended by filling upper bits with its sign.
// - The short jump and any satisfied conditional branch use the relative target.
// - Absolute call and jump copy the immediate address into the counter.
// - Absolute targets may be any location in the full address space.
`timescale 1ns/1ps
`default_nettype none
`include "pcbu_regs.svh"
module pcbu_core #(
    parameter int PC_W = `PCBU_PC_W,
    parameter logic [`PCBU_PC_W-1:0] RESET_PC = `PCBU_PC_RESET
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Decoder side
    input wire logic i_valid,
    input wire pcbu_pkg::pcbu_instr_t i_instr,
    // Fetch side
    output logic [PC_W-1:0] o_pc,
    output logic o_taken,
    output logic o_redirect,
    output logic o_call
);
    // ----------------------------------------------------------------
    // Next address
    // ----------------------------------------------------------------
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    logic [PC_W-1:0] seq_pc;
    logic [PC_W-1:0] rel_target;
    logic take_rel;
    logic take_abs;
    pcbu_pkg::pcbu_state_t state_r;

    assign seq_pc = pc_r + {{(PC_W-`PCBU_LEN_W){1'b0}}, i_instr.length};

    pcbu_target #(
        .PC_W(PC_W),
        .DISP_W(`PCBU_DISP_W)
    ) u_target (
        .i_next_pc(seq_pc),
        .i_disp(i_instr.displacement),
        .o_target(rel_target)
    );

    assign take_rel = i_valid && (i_instr.op == pcbu_pkg::PCBU_OP_REL)
                      && (!i_instr.cond_branch || i_instr.cond_met);
    assign take_abs = i_valid && ((i_instr.op == pcbu_pkg::PCBU_OP_ABS_JMP)
                      || (i_instr.op == pcbu_pkg::PCBU_OP_ABS_CALL));

    always_comb begin
        pc_nxt = pc_r;
        if (take_abs) begin
            pc_nxt = i_instr.target;
        end else if (take_rel) begin
            pc_nxt = rel_target;
        end else if (i_valid) begin
            pc_nxt = seq_pc;
        end
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    // Counter only moves on a valid instruction so a stalled decoder holds it
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pc_r <= RESET_PC;
        end else if (i_ce) begin
            pc_r <= pc_nxt;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= pcbu_pkg::PCBU_ST_RUN;
            o_call <= 1'b0;
        end else if (i_ce) begin
            o_call <= i_valid && (i_instr.op == pcbu_pkg::PCBU_OP_ABS_CALL);
            case (state_r)
                pcbu_pkg::PCBU_ST_RUN: begin
                    if (take_rel || take_abs) begin
                        state_r <= pcbu_pkg::PCBU_ST_REDIRECT;
                    end
                end
                pcbu_pkg::PCBU_ST_REDIRECT: begin
                    if (!(take_rel || take_abs)) begin
                        state_r <= pcbu_pkg::PCBU_ST_RUN;
                    end
                end
                default: begin
                    state_r <= pcbu_pkg::PCBU_ST_RUN;
                end
            endcase
        end
    end

    assign o_pc = pc_r;
    assign o_redirect = (state_r == pcbu_pkg::PCBU_ST_REDIRECT);
    // Combinational so fetch can squash the sequential prefetch in the same cycle
    assign o_taken = take_rel || take_abs;
endmodule : pcbu_core
`default_nettype wire

//--- tb/pcbu_decoder_model.sv
// Decoder stand-in that turns a random word into an instruction
`timescale 1ns/1ps
`default_nettype none
module pcbu_decoder_model (
    // Random word in, instruction out
    input wire logic [31:0] i_rnd,
    output var pcbu_pkg::pcbu_instr_t o_instr
);
    // Bias reaches both displacement ends and addresses near the top of memory
    assign o_instr = {i_rnd[30:24], i_rnd[31] ? {i_rnd[0], {7{~i_rnd[0]}}} : i_rnd[23:16],
        i_rnd[15:13] == 3'h7 ? 16'hFFFE : i_rnd[15:0]};
endmodule : pcbu_decoder_model
`default_nettype wire

//--- tb/pcbu_core_asserts.sv
// Assertions on the ports of the branch unit
`timescale 1ns/1ps
`default_nettype none
module pcbu_core_asserts (
    // Clock, reset and decoder side
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_valid,
    input wire pcbu_pkg::pcbu_instr_t i_instr,
    // Fetch side
    input wire logic [15:0] o_pc,
    input wire logic o_taken,
    input wire logic o_redirect,
    input wire logic o_call
);
    wire logic e = i_ce & i_valid;
    wire logic [15:0] nx = o_pc + 16'(i_instr.length);
    wire logic [15:0] rt = nx + {{8{i_instr.displacement[7]}}, i_instr.displacement};
    wire logic is_rel = i_instr.op == pcbu_pkg::PCBU_OP_REL;
    wire logic is_seq = i_instr.op == pcbu_pkg::PCBU_OP_SEQ;
    wire logic is_call = i_instr.op == pcbu_pkg::PCBU_OP_ABS_CALL;
    wire logic go = is_rel && !(i_instr.cond_branch && !i_instr.cond_met);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    sequence rel_go; e && go; endsequence
    chk_seq_step: assert property (
        e && is_seq |=> o_pc == $past(nx))
        else $error("sequential step wrong");
    chk_rel_target: assert property (
        rel_go |=> o_pc == $past(rt))
        else $error("relative target wrong");
    chk_cond_skip: assert property (
        e && is_rel && !go |=> o_pc == $past(nx))
        else $error("untaken branch moved");
    chk_abs_load: assert property (
        e && i_instr.op[1] |=> o_pc == $past(i_instr.target))
        else $error("absolute target wrong");
    chk_pc_hold: assert property (
        !e |=> $stable(o_pc))
        else $error("counter moved while idle");
    chk_taken_flag: assert property (
        i_ce |-> o_taken == (i_valid && (i_instr.op[1] || go)))
        else $error("taken flag wrong");
    chk_redirect_flag: assert property (
        i_ce |=> o_redirect == $past(o_taken))
        else $error("redirect flag wrong");
    chk_call_flag: assert property (
        i_ce |=> o_call == $past(e && is_call))
        else $error("call flag wrong");
endmodule : pcbu_core_asserts
bind pcbu_core pcbu_core_asserts chk (.*);
`default_nettype wire

//--- tb/program_counter_branch_unit_bench.sv
// Random self-checking bench for the branch unit
`timescale 1ns/1ps
`default_nettype none
module program_counter_branch_unit_bench;
    logic i_mclk = 0, i_rst_n = 0, i_ce = 0, i_valid = 0, tk, erd = 0, ecl = 0;
    logic [31:0] rnd = 0, c;
    int seed = 32'h160f351b, miscompares = 0, check_count = 0, pc = 0;
    pcbu_pkg::pcbu_instr_t ins;
    logic [15:0] o_pc;
    logic o_taken, o_redirect, o_call;
    always #12.5 i_mclk = ~i_mclk;
    pcbu_decoder_model dec (.i_rnd(rnd), .o_instr(ins));
    pcbu_core dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_valid(i_valid),
        .i_instr(ins), .o_pc(o_pc), .o_taken(o_taken), .o_redirect(o_redirect), .o_call(o_call));
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task final_report;
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (4) @(posedge i_mclk);
        @(negedge i_mclk) i_rst_n = 1;
        repeat (400) begin
            @(negedge i_mclk);
            rnd = $random(seed);
            c = $random(seed);
            i_ce = c[0] | c[1];
            i_valid = c[2] | c[3];
            #1 tk = i_valid && (ins.op[1] || ins.op == pcbu_pkg::PCBU_OP_REL && !(ins.cond_branch && !ins.cond_met));
            if (i_ce) chk(o_taken, tk);
            if (i_ce && i_valid) pc = ins.op[1] ? int'(ins.target) : (pc + int'(ins.length)
                + (tk ? int'($signed(ins.displacement)) : 0)) & 16'hFFFF;
            if (i_ce) {erd, ecl} = {tk, i_valid && ins.op == pcbu_pkg::PCBU_OP_ABS_CALL};
            @(posedge i_mclk) #1;
            chk(o_pc, pc[15:0]);
            chk({o_redirect, o_call}, {erd, ecl});
        end
        final_report();
    end
    initial begin
        #20000 miscompares++;
        final_report();
    end
endmodule : program_counter_branch_unit_bench
`default_nettype wire
